// >>> core/qpsd_defines.svh
/*
 Constants of the quad potentiometer serial command decoder: frame
 layout, fixed field codes, reset values and the write cycle time.
 Assumes inclusion by every design file that needs a number.
*/
`ifndef QPSD_DEFINES_SVH
`define QPSD_DEFINES_SVH

// ==========================================================================
// Frame layout
// ==========================================================================
`define QPSD_DEV_ID       4'h5
`define QPSD_ADDR_PAD     2'h0
`define QPSD_STATUS_SEL   4'h1
`define QPSD_STATUS_PAD   7'h00
`define QPSD_BIT_HDR      5'h07
`define QPSD_BIT_CMD      5'h0f
`define QPSD_BIT_DATA     5'h17
`define QPSD_BIT_END      5'h18

// ==========================================================================
// Register values
// ==========================================================================
`define QPSD_WIPER_RST    8'h00
`define QPSD_STORED_RST   8'h00
`define QPSD_WIPER_MAX    8'hff
`define QPSD_WIPER_MIN    8'h00

// ==========================================================================
// Timing
// ==========================================================================
`define QPSD_CLK_HZ       20000000
`define QPSD_NV_WRITE_US  10000
`define QPSD_NV_CYCLES    (`QPSD_NV_WRITE_US * (`QPSD_CLK_HZ / 1000000))

`endif

// >>> core/qpsd_pkg.sv
/*
 Types of the quad potentiometer serial command decoder.
 Assumes nothing of its surroundings.
*/
package qpsd_pkg;

   typedef logic [7:0] qpsd_byte_t;

   typedef enum logic [3:0] {
      op_rd_wiper  = 4'b1001,
      op_wr_wiper  = 4'b1010,
      op_rd_stored = 4'b1011,
      op_wr_stored = 4'b1100,
      op_sgl_load  = 4'b1101,
      op_sgl_save  = 4'b1110,
      op_glb_load  = 4'b0001,
      op_glb_save  = 4'b1000,
      op_step      = 4'b0010,
      op_status    = 4'b0101
   } qpsd_op_e;

endpackage

// >>> core/qpsd_nv_if.sv
/*
 Link between the command decoder and its nonvolatile store.
 Assumes both ends run on clk_sys.
*/
`timescale 1ns/1ps
interface qpsd_nv_if;
   logic         start;
   logic [3:0]   mask;
   logic [1:0]   rsel;
   logic [31:0]  wdata;
   logic         busy;
   logic [127:0] stored;

   modport ctl (output start, mask, rsel, wdata, input busy, stored);
   modport mem (input start, mask, rsel, wdata, output busy, stored);
endinterface

// >>> core/qpsd_nvstore.sv
/*
 Stored position memory: sixteen bytes, four per pot, written by a
 timed nonvolatile write cycle.
 Assumes start is a one-cycle pulse on clk_sys; a start while busy
 is dropped.
*/
`timescale 1ns/1ps
`include "qpsd_defines.svh"
module qpsd_nvstore #(
   parameter int unsigned CYCLES = `QPSD_NV_CYCLES
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   qpsd_nv_if.mem   nv
);
   localparam int CW = $clog2(CYCLES + 1);

   logic [CW-1:0] cnt_q;
   logic          busy_q;
   logic [3:0]    mask_q;
   logic [1:0]    rsel_q;
   logic [31:0]   wdata_q;
   logic [7:0]    mem_q [16];

   // ========================================================================
   // Write cycle timer
   // ========================================================================
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         busy_q  <= 1'b0;
         cnt_q   <= '0;
         mask_q  <= 4'h0;
         rsel_q  <= 2'h0;
         wdata_q <= 32'h0000_0000;
      end else if (!busy_q && nv.start) begin
         busy_q  <= 1'b1; // R16
         cnt_q   <= CW'(CYCLES - 1);
         mask_q  <= nv.mask;
         rsel_q  <= nv.rsel;
         wdata_q <= nv.wdata;
      end else if (busy_q) begin
         if (cnt_q == '0) begin
            busy_q <= 1'b0; // R16
         end else begin
            cnt_q <= cnt_q - CW'(1);
         end
      end
   end

   // ========================================================================
   // Storage, committed as the cycle completes
   // ========================================================================
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         for (int i = 0; i < 16; i++) begin
            mem_q[i] <= `QPSD_STORED_RST;
         end
      end else if (busy_q && cnt_q == '0) begin
         for (int p = 0; p < 4; p++) begin
            if (mask_q[p]) begin
               mem_q[{rsel_q, 2'(p)}] <= wdata_q[p*8 +: 8]; // R04 R06 R07
            end
         end
      end
   end

   always_comb begin
      for (int i = 0; i < 16; i++) begin
         nv.stored[i*8 +: 8] = mem_q[i];
      end
   end

   assign nv.busy = busy_q;
endmodule

// >>> core/qpsd_top.sv
/*
 Serial command decoder of a four channel digital potentiometer.
 The frame logic runs on sck; its bit counter and read enables are cleared while cs_n is high; the
 wiper registers and the store run on clk_sys. Commands take effect
 when the clk_sys side sees cs_n rise. Assumes the host leaves cs_n
 high for at least four clk_sys periods between frames, so that the
 quasi-static words read across the domains have settled.
*/
// Contract
// R01 - Frame spans cs_n low; act only on 0101, 00 and strapped address.
// R02 - Opcode 1010 plus pot select, then data byte loads that wiper register.
// R03 - Opcode 1011 returns the selected stored byte on so, MSB first.
// R04 - Opcode 1100 writes the data byte to stored register after cs_n rise.
// R05 - Opcode 0001 copies each pot's selected stored register into its wiper.
// R06 - Opcode 1000 at cs_n rise saves all wipers to the selected registers.
// R07 - Opcode 1110 at cs_n rise saves one wiper to its selected register.
// R08 - Opcode 1101 copies one selected stored register into its pot wiper.
// R09 - Opcode 0010 then any number of step bits, applied until cs_n rises.
// R10 - During stepping, a clock with si high increments the wiper by one.
// R11 - During stepping, a clock with si low decrements the wiper by one.
// R12 - Opcode 0101, byte 0001: seven zeros then write-in-progress as LSB.
// R13 - Opcode 1001 returns the selected wiper value on so in byte three.
// R14 - Increment moves toward the high terminal, decrement toward the low.
// R15 - Sample si on rising sck, drive so on falling; release so otherwise.
// R16 - Write-in-progress is high from start to end of a nonvolatile write.
`timescale 1ns/1ps
`include "qpsd_defines.svh"
module qpsd_top #(
   parameter int unsigned NV_CYCLES = `QPSD_NV_CYCLES
) (
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   input  wire logic        sck,
   input  wire logic        cs_n,
   input  wire logic        si,
   input  wire logic        chip_addr_hi,
   input  wire logic        chip_addr_lo,
   output logic             so,
   output logic             so_oe,
   output logic [31:0]      wiper_tap_value,
   output logic             write_in_progress
);

   qpsd_nv_if nv ();

   logic [3:0][7:0] wiper_q;

   // ========================================================================
   // Helpers
   // ========================================================================
   function automatic logic cmd_legal(input logic [7:0] c);
      qpsd_pkg::qpsd_op_e op;
      op = qpsd_pkg::qpsd_op_e'(c[7:4]);
      case (op)
         qpsd_pkg::op_rd_wiper, qpsd_pkg::op_wr_wiper:
            cmd_legal = (c[3:2] == 2'h0);
         qpsd_pkg::op_rd_stored, qpsd_pkg::op_wr_stored,
         qpsd_pkg::op_sgl_load, qpsd_pkg::op_sgl_save,
         qpsd_pkg::op_step:
            cmd_legal = 1'b1;
         qpsd_pkg::op_glb_load, qpsd_pkg::op_glb_save:
            cmd_legal = (c[1:0] == 2'h0);
         qpsd_pkg::op_status:
            cmd_legal = (c[3:0] == `QPSD_STATUS_SEL);
         default:
            cmd_legal = 1'b0;
      endcase
   endfunction

   function automatic logic is_read(input logic [3:0] o);
      is_read = (o == qpsd_pkg::op_rd_wiper) ||
                (o == qpsd_pkg::op_rd_stored) ||
                (o == qpsd_pkg::op_status);
   endfunction

   function automatic logic is_write3(input logic [3:0] o);
      is_write3 = (o == qpsd_pkg::op_wr_wiper) ||
                  (o == qpsd_pkg::op_wr_stored);
   endfunction

   function automatic logic [7:0] stored_at(input logic [127:0] v,
                                            input logic [3:0]   idx);
      stored_at = v[idx*8 +: 8];
   endfunction

   // ========================================================================
   // Link side synchronisers
   // ========================================================================
   logic [1:0] rst_sck_q;
   logic [1:0] addr_m_q;
   logic [1:0] addr_s_q;
   logic [1:0] wip_sck_q;

   always_ff @(posedge sck) begin
      rst_sck_q <= {rst_sck_q[0], rst_n};
      addr_m_q  <= {chip_addr_hi, chip_addr_lo};
      addr_s_q  <= addr_m_q;
      wip_sck_q <= {wip_sck_q[0], write_in_progress};
   end

   // ========================================================================
   // Frame shifter; only the bit counter is cleared while cs_n is high
   // ========================================================================
   logic [4:0] bit_cnt_q;
   logic [7:0] sh_q;
   logic [7:0] byte_in;

   assign byte_in = {sh_q[6:0], si};

   always_ff @(posedge sck or posedge cs_n) begin
      if (cs_n) begin
         bit_cnt_q <= 5'h00; // R01
      end else if (bit_cnt_q != `QPSD_BIT_END) begin
         bit_cnt_q <= bit_cnt_q + 5'h01;
      end
   end

   always_ff @(posedge sck) begin
      sh_q <= byte_in; // R15
   end

   // ========================================================================
   // Header, command and data capture
   // ========================================================================
   logic       hdr_ok_q;
   logic       cmd_ok_q;
   logic [7:0] cmd_q;
   logic [7:0] data_q;
   logic       commit_q;
   logic [7:0] step_q;

   always_ff @(posedge sck) begin
      if (rst_sck_q[1] == 1'b0) begin
         hdr_ok_q <= 1'b0;
         cmd_ok_q <= 1'b0;
         cmd_q    <= 8'h00;
         data_q   <= 8'h00;
      end else begin
         if (bit_cnt_q == `QPSD_BIT_HDR) begin
            hdr_ok_q <= (byte_in == {`QPSD_DEV_ID, `QPSD_ADDR_PAD,
                                     addr_s_q}); // R01
         end
         if (bit_cnt_q == `QPSD_BIT_CMD) begin
            cmd_q    <= byte_in;
            cmd_ok_q <= hdr_ok_q && cmd_legal(byte_in);
         end
         if (bit_cnt_q == `QPSD_BIT_DATA) begin
            data_q <= byte_in; // R02 R04
         end
      end
   end

   // A frame's command is handed over only once it is complete.
   always_ff @(posedge sck) begin
      if (rst_sck_q[1] == 1'b0) begin
         commit_q <= 1'b0;
      end else if (bit_cnt_q == 5'h00) begin
         commit_q <= 1'b0;
      end else if (bit_cnt_q == `QPSD_BIT_CMD) begin
         commit_q <= hdr_ok_q && cmd_legal(byte_in) &&
                     !is_read(byte_in[7:4]) &&
                     !is_write3(byte_in[7:4]); // R05 R06 R07 R08 R09
      end else if (bit_cnt_q == `QPSD_BIT_DATA) begin
         commit_q <= commit_q || (cmd_ok_q && is_write3(cmd_q[7:4]));
      end
   end

   // ========================================================================
   // Stepping, saturating at the ends of the resistor array
   // ========================================================================
   always_ff @(posedge sck) begin
      if (rst_sck_q[1] == 1'b0) begin
         step_q <= `QPSD_WIPER_RST;
      end else if (bit_cnt_q == `QPSD_BIT_CMD) begin
         step_q <= wiper_q[byte_in[1:0]]; // R09
      end else if (bit_cnt_q > `QPSD_BIT_CMD && cmd_ok_q &&
                   cmd_q[7:4] == qpsd_pkg::op_step) begin
         if (si && step_q != `QPSD_WIPER_MAX) begin
            step_q <= step_q + 8'h01; // R10 R14
         end else if (!si && step_q != `QPSD_WIPER_MIN) begin
            step_q <= step_q - 8'h01; // R11 R14
         end
      end
   end

   // ========================================================================
   // Read data path
   // ========================================================================
   logic [7:0] tx_q;
   logic       rd_q;
   logic [7:0] rd_byte;

   always_comb begin
      case (byte_in[7:4])
         qpsd_pkg::op_rd_wiper:
            rd_byte = wiper_q[byte_in[1:0]]; // R13
         qpsd_pkg::op_rd_stored:
            rd_byte = stored_at(nv.stored, byte_in[3:0]); // R03
         qpsd_pkg::op_status:
            rd_byte = {`QPSD_STATUS_PAD, wip_sck_q[1]}; // R12
         default:
            rd_byte = 8'h00;
      endcase
   end

   always_ff @(posedge sck or posedge cs_n) begin
      if (cs_n) begin
         rd_q <= 1'b0;
      end else if (bit_cnt_q == `QPSD_BIT_CMD) begin
         rd_q <= hdr_ok_q && cmd_legal(byte_in) && is_read(byte_in[7:4]);
      end
   end

   always_ff @(posedge sck) begin
      if (bit_cnt_q == `QPSD_BIT_CMD) begin
         tx_q <= rd_byte;
      end else begin
         tx_q <= {tx_q[6:0], 1'b0};
      end
   end

   always_ff @(negedge sck or posedge cs_n) begin
      if (cs_n) begin
         so_oe <= 1'b0; // R15
         so    <= 1'b0;
      end else begin
         so_oe <= rd_q && (bit_cnt_q != `QPSD_BIT_END); // R15
         so    <= tx_q[7]; // R03 R12 R13
      end
   end

   // ========================================================================
   // System side: frame end detection
   // ========================================================================
   logic [2:0] cs_q;
   logic [1:0] cmt_q;
   logic       exec;
   logic [3:0] op_s;
   logic [1:0] pot_s;
   logic [1:0] reg_s;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         cs_q  <= 3'h7;
         cmt_q <= 2'h0;
      end else begin
         cs_q  <= {cs_q[1:0], cs_n};
         cmt_q <= {cmt_q[0], commit_q};
      end
   end

   // The frame words are still while sck idles after cs_n has risen.
   assign exec  = cs_q[1] && !cs_q[2] && cmt_q[1];
   assign op_s  = cmd_q[7:4];
   assign reg_s = cmd_q[3:2];
   assign pot_s = cmd_q[1:0];

   // ========================================================================
   // Wiper registers
   // ========================================================================
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         wiper_q <= {4{`QPSD_WIPER_RST}};
      end else if (exec) begin
         case (op_s)
            qpsd_pkg::op_wr_wiper:
               wiper_q[pot_s] <= data_q; // R02
            qpsd_pkg::op_sgl_load:
               wiper_q[pot_s] <= stored_at(nv.stored, {reg_s, pot_s}); // R08
            qpsd_pkg::op_glb_load: begin
               for (int p = 0; p < 4; p++) begin
                  wiper_q[p] <= stored_at(nv.stored,
                                          {reg_s, 2'(p)}); // R05
               end
            end
            qpsd_pkg::op_step:
               wiper_q[pot_s] <= step_q; // R09
            default: begin
            end
         endcase
      end
   end

   assign wiper_tap_value = wiper_q;

   // ========================================================================
   // Nonvolatile write requests
   // ========================================================================
   logic        start_q;
   logic [3:0]  mask_q;
   logic [1:0]  rsel_q;
   logic [31:0] wdata_q;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         start_q <= 1'b0;
         mask_q  <= 4'h0;
         rsel_q  <= 2'h0;
         wdata_q <= 32'h0000_0000;
      end else begin
         start_q <= 1'b0;
         if (exec && !nv.busy && !start_q) begin
            rsel_q <= reg_s;
            case (op_s)
               qpsd_pkg::op_wr_stored: begin
                  start_q <= 1'b1; // R04
                  mask_q  <= 4'h1 << pot_s;
                  wdata_q <= {4{data_q}};
               end
               qpsd_pkg::op_sgl_save: begin
                  start_q <= 1'b1; // R07
                  mask_q  <= 4'h1 << pot_s;
                  wdata_q <= wiper_q;
               end
               qpsd_pkg::op_glb_save: begin
                  start_q <= 1'b1; // R06
                  mask_q  <= 4'hf;
                  wdata_q <= wiper_q;
               end
               default: begin
               end
            endcase
         end
      end
   end

   assign nv.start = start_q;
   assign nv.mask  = mask_q;
   assign nv.rsel  = rsel_q;
   assign nv.wdata = wdata_q;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         write_in_progress <= 1'b0;
      end else begin
         write_in_progress <= start_q || nv.busy; // R16
      end
   end

   qpsd_nvstore #(
      .CYCLES (NV_CYCLES)
   ) u_store (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .nv      (nv)
   );
endmodule

// >>> sim/qpsd_top_sva.sv
/*
 Port checker of the potentiometer command decoder.
 Assumes binding to qpsd_top and a host that keeps frame spacing.
*/
`timescale 1ns/1ps
module qpsd_top_sva #(
   parameter int unsigned NV_CYCLES = 16
) (
   input wire logic        clk_sys,
   input wire logic        rst_n,
   input wire logic        sck,
   input wire logic        cs_n,
   input wire logic        si,
   input wire logic        chip_addr_hi,
   input wire logic        chip_addr_lo,
   input wire logic        so,
   input wire logic        so_oe,
   input wire logic [31:0] wiper_tap_value,
   input wire logic        write_in_progress
);
   logic [4:0]  rise_q;
   logic [15:0] hdr_q;
   logic [31:0] wip_q;
   logic        hit;
   logic        rd_op;

   // ======================================================================
   // Frame tracking
   always_ff @(posedge sck or posedge cs_n) begin
      if (cs_n) begin
         rise_q <= 5'h00;
      end else if (rise_q != 5'h1f) begin
         rise_q <= rise_q + 5'h01;
      end
   end
   always_ff @(posedge sck or posedge cs_n) begin
      if (cs_n) begin
         hdr_q <= 16'h0000;
      end else if (rise_q < 5'h10) begin
         hdr_q <= {hdr_q[14:0], si};
      end
   end
   always_ff @(posedge clk_sys) begin
      if (!rst_n || !write_in_progress) begin
         wip_q <= 32'h0;
      end else begin
         wip_q <= wip_q + 32'h1;
      end
   end
   assign hit = hdr_q[15:8] == {4'h5, 2'h0, chip_addr_hi, chip_addr_lo};
   assign rd_op = hdr_q[7:4] inside {4'h9, 4'hb, 4'h5};

   // ======================================================================
   // Assertions
   AST_SO_IDLE: assert property (@(posedge clk_sys) disable iff (!rst_n)
      cs_n && $past(cs_n) |-> !so_oe && !so)
      else $error("so driven while deselected");
   AST_WIPER_HOLD: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      (!cs_n) [*6] |-> $stable(wiper_tap_value))
      else $error("wiper moved inside a frame");
   AST_WIPER_AT_END: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      $changed(wiper_tap_value) |-> $past(cs_n, 2))
      else $error("wiper changed too soon after select");
   AST_WIP_CAUSE: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      $rose(write_in_progress) |-> $past(cs_n, 3))
      else $error("write cycle began without frame end");
   AST_WIP_LEN: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $fell(write_in_progress) |-> wip_q == NV_CYCLES + 1)
      else $error("write cycle length wrong");
   AST_OE_WINDOW: assert property (@(negedge sck) disable iff (cs_n)
      so_oe |-> rise_q inside {[5'h11:5'h18]})
      else $error("so enabled outside data byte");
   AST_OE_READ: assert property (@(negedge sck) disable iff (cs_n)
      so_oe |-> hit && rd_op)
      else $error("so enabled for a non-read frame");
   AST_STATUS_PAD: assert property (@(negedge sck) disable iff (cs_n)
      hit && hdr_q[7:0] == 8'h51 && rise_q inside {[5'h11:5'h17]} |-> !so)
      else $error("status pad bit not zero");
   AST_REFUSE: assert property (@(negedge sck) disable iff (cs_n)
      !hit |-> !so_oe)
      else $error("foreign frame answered");
   cover property (@(posedge clk_sys) $fell(write_in_progress));
   cover property (@(negedge sck) so_oe && rise_q == 5'h18);
   cover property (@(posedge clk_sys) $changed(wiper_tap_value));
endmodule

bind qpsd_top qpsd_top_sva #(.NV_CYCLES(NV_CYCLES)) u_sva (
   .clk_sys(clk_sys), .rst_n(rst_n), .sck(sck), .cs_n(cs_n), .si(si),
   .chip_addr_hi(chip_addr_hi), .chip_addr_lo(chip_addr_lo), .so(so),
   .so_oe(so_oe), .wiper_tap_value(wiper_tap_value),
   .write_in_progress(write_in_progress));

// >>> sim/qpsd_host.sv
/*
 Serial host model: frames commands with cs_n at a 48 ns sck.
 Assumes the caller spaces frames only through xfer.
*/
`timescale 1ns/1ps
module qpsd_host (
   output logic      sck,
   output logic      cs_n,
   output logic      si,
   input  wire logic so
);
   // A late rise of cs_n gives the frame logic a clean edge to clear on.
   initial begin
      sck = 1'b0;
      si = 1'b0;
      #1;
      cs_n = 1'b1;
   end
   // Sends the low n bits of word msb first; keeps so at rises 16..23.
   task automatic xfer(input logic [31:0] word, input int n,
                       output logic [7:0] rd);
      rd = 8'h00;
      cs_n = 1'b0;
      #24;
      for (int i = n - 1; i >= 0; i--) begin
         si = word[i];
         #12;
         sck = 1'b1;
         if (n - 1 - i >= 16 && n - 1 - i < 24) begin
            rd = {rd[6:0], so};
         end
         #24;
         sck = 1'b0;
         #12;
      end
      #24;
      cs_n = 1'b1;
      si = ~si;
      #400;
   endtask
endmodule

// >>> sim/qpsd_top_tb.sv
/*
 Testbench of the potentiometer command decoder.
 Assumes the host model and the port checker bound to the top.
*/
`timescale 1ns/1ps
module qpsd_top_tb;
   logic        clk_sys;
   logic        rst_n;
   logic        sck;
   logic        cs_n;
   logic        si;
   logic        so;
   logic        so_oe;
   logic        wip;
   logic [31:0] taps;
   logic [7:0]  rd;
   logic [7:0]  hdr;
   logic [7:0]  wexp [4];
   logic [7:0]  sexp [16];
   int          err_count;
   int          n_checks;
   int          oe_n;

   qpsd_top #(.NV_CYCLES(64)) u_dut (
      .clk_sys(clk_sys), .rst_n(rst_n), .sck(sck), .cs_n(cs_n), .si(si),
      .chip_addr_hi(1'b1), .chip_addr_lo(1'b0), .so(so), .so_oe(so_oe),
      .wiper_tap_value(taps), .write_in_progress(wip));
   qpsd_host u_host (.sck(sck), .cs_n(cs_n), .si(si), .so(so));

   // Counts the rising sck edges at which the device drives so.
   always @(posedge sck) if (so_oe === 1'b1) oe_n++;

   // ======================================================================
   // Helpers
   task automatic chk(input string what, input logic [31:0] seen,
                      input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic cmd(input logic [3:0] op, input logic [3:0] sel,
                      input logic [7:0] d, input int n);
      u_host.xfer({8'h00, hdr, op, sel, d} >> (24 - n), n, rd);
   endtask
   task automatic wait_idle;
      repeat (200) if (wip === 1'b1) @(posedge clk_sys);
      #1;
      chk("idle", wip, 1'b0);
   endtask
   task automatic finish_test;
      if (err_count == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // ======================================================================
   // Scenarios
   task automatic t_wiper;
      for (int p = 0; p < 4; p++) begin
         wexp[p] = 8'h40 + 8'(p * 37);
         cmd(4'ha, 4'(p), wexp[p], 24);
      end
      chk("taps", taps, {wexp[3], wexp[2], wexp[1], wexp[0]});
      oe_n = 0;
      for (int p = 0; p < 4; p++) begin
         cmd(4'h9, 4'(p), 8'h00, 24);
         chk("wiper read", rd, wexp[p]);
      end
      chk("so_oe bits", oe_n, 32);
   endtask
   task automatic t_refused;
      hdr = 8'h51;
      cmd(4'ha, 4'h0, 8'h77, 24);
      oe_n = 0;
      cmd(4'h9, 4'h0, 8'h00, 24);
      chk("so_oe refused", oe_n, 0);
      hdr = 8'h62;
      cmd(4'ha, 4'h1, 8'h77, 24);
      hdr = 8'h52;
      chk("taps", taps, {wexp[3], wexp[2], wexp[1], wexp[0]});
   endtask
   task automatic t_stored;
      sexp[9] = 8'hc3;
      cmd(4'hc, 4'h9, 8'hc3, 24);
      chk("busy", wip, 1'b1);
      cmd(4'h5, 4'h1, 8'h00, 24);
      chk("status busy", rd, 8'h01);
      wait_idle;
      cmd(4'h5, 4'h1, 8'h00, 24);
      chk("status idle", rd, 8'h00);
      cmd(4'hb, 4'h9, 8'h00, 24);
      chk("stored read", rd, sexp[9]);
   endtask
   task automatic t_xfer;
      cmd(4'hd, 4'h9, 8'h00, 16);
      wexp[1] = sexp[9];
      chk("taps", taps, {wexp[3], wexp[2], wexp[1], wexp[0]});
      cmd(4'he, 4'hc, 8'h00, 16);
      wait_idle;
      cmd(4'hb, 4'hc, 8'h00, 24);
      chk("single save", rd, wexp[0]);
      cmd(4'h8, 4'h4, 8'h00, 16);
      wait_idle;
      cmd(4'hb, 4'h7, 8'h00, 24);
      chk("global save", rd, wexp[3]);
      cmd(4'h1, 4'h8, 8'h00, 16);
      for (int p = 0; p < 4; p++) wexp[p] = sexp[8 + p];
      chk("taps", taps, {wexp[3], wexp[2], wexp[1], wexp[0]});
   endtask
   task automatic t_step;
      cmd(4'h2, 4'h2, 8'hd8, 21);
      chk("step mix", taps[23:16], 8'h03);
      cmd(4'h2, 4'h2, 8'h00, 24);
      chk("step down", taps[23:16], 8'h00);
      cmd(4'ha, 4'h3, 8'hfe, 24);
      cmd(4'h2, 4'h3, 8'he0, 19);
      chk("step up", taps[31:24], 8'hff);
   endtask

   // ======================================================================
   // Sequence
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   initial begin
      rst_n = 1'b0;
      hdr = 8'h52;
      err_count = 0;
      n_checks = 0;
      for (int i = 0; i < 16; i++) sexp[i] = 8'h00;
      for (int i = 0; i < 4; i++) wexp[i] = 8'h00;
      repeat (10) @(posedge clk_sys);
      #1 rst_n = 1'b1;
      repeat (3) @(posedge clk_sys);
      #1;
      t_wiper;
      t_refused;
      t_stored;
      t_xfer;
      t_step;
      finish_test;
   end
   initial begin
      #500000;
      err_count++;
      finish_test;
   end
endmodule
